// File: cpu_register_file_and_flags.sv
/*
  Register set of the processor core: eight word registers split into
  byte halves, the instruction pointer and the condition flags.
  Assumes the execution sequencer drives one request per cycle and
  supplies the reset vector word when asked for it.
*/
`timescale 1ns/10ps
module cpu_register_file_and_flags
  import regfile_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  // write port
  input wire logic wr_en,
  input wire logic [idx_w-1:0] wr_idx,
  input wire logic wr_hi,
  input wire logic wr_lo,
  input wire logic [word_w-1:0] wr_data,
  // data read ports
  input wire logic [idx_w-1:0] rd_a_idx,
  input wire logic rd_a_byte,
  input wire logic rd_a_hi,
  input wire logic [idx_w-1:0] rd_b_idx,
  input wire logic rd_b_byte,
  input wire logic rd_b_hi,
  output logic [word_w-1:0] rd_a_data,
  output logic [word_w-1:0] rd_b_data,
  // address read
  input wire logic [idx_w-1:0] addr_idx,
  output logic [word_w-1:0] addr_out,
  output logic [word_w-1:0] stack_top_pointer,
  // instruction pointer
  input wire logic ip_load,
  input wire logic ip_step,
  input wire logic [word_w-1:0] ip_data,
  output logic [word_w-1:0] next_instruction_pointer,
  // reset vector fetch
  output logic vector_req,
  output logic [word_w-1:0] vector_addr,
  input wire logic vector_valid,
  input wire logic [word_w-1:0] vector_data,
  // arithmetic
  input alu_op_t alu_op,
  input wire logic alu_word,
  input wire logic alu_dst_en,
  input wire logic [word_w-1:0] alu_a,
  input wire logic [word_w-1:0] alu_b,
  input wire logic alu_shift_out,
  input wire logic alu_bit_value,
  output logic [word_w-1:0] alu_result,
  // flag register access by software
  input flag_op_t flag_op,
  input wire logic [byte_w-1:0] flag_imm,
  input wire logic [word_w-1:0] flag_pop_word,
  input wire logic exception_start,
  output logic [byte_w-1:0] condition_flags,
  output logic [word_w-1:0] flag_push_word,
  output logic irq_masked,
  input branch_cond_t branch_cond,
  output logic branch_taken,
  output logic core_ready
);
  logic [byte_w-1:0] upper_byte_regs [reg_count];
  logic [byte_w-1:0] lower_byte_regs [reg_count];
  logic [word_w-1:0] word_general_regs [reg_count];
  logic [word_w-1:0] ip_reg;
  logic [word_w-1:0] ip_next;
  logic [byte_w-1:0] flags_reg;
  logic [byte_w-1:0] flags_next;
  logic [word_w-1:0] rd_a_next;
  logic [word_w-1:0] rd_b_next;
  logic [word_w-1:0] wb_data;
  logic wb_hi;
  logic wb_lo;
  logic wb_en;
  logic taken_comb;
  core_state_t state_reg;
  core_state_t state_next;
  flag_bus_if fb();

  // ==========================================================
  // general registers
  // word view is just the pairing of the two byte arrays
  genvar gi;
  generate
    for (gi = 0; gi < reg_count; gi++) begin : g_pair
      assign word_general_regs[gi] = {upper_byte_regs[gi],
        lower_byte_regs[gi]};
    end
  endgenerate

  // arithmetic results write back into the destination register
  always_comb begin
    wb_en = wr_en | alu_dst_en;
    wb_data = alu_dst_en ? fb.result : wr_data;
    wb_hi = alu_dst_en ? alu_word : wr_hi;
    wb_lo = alu_dst_en ? 1'b1 : wr_lo;
  end

  // no reset: contents stay undefined until software loads them
  generate
    for (gi = 0; gi < reg_count; gi++) begin : g_store
      always_ff @(posedge clk_sys) begin
        if (wb_en && (wr_idx == idx_w'(gi)) && wb_hi && alu_word
            && alu_dst_en) begin
          upper_byte_regs[gi] <= wb_data[word_w-1:byte_w];
        end else if (wb_en && !alu_dst_en && (wr_idx == idx_w'(gi))
            && wb_hi) begin
          upper_byte_regs[gi] <= wr_hi && !wr_lo ? wb_data[byte_w-1:0]
            : wb_data[word_w-1:byte_w];
        end
        if (wb_en && (wr_idx == idx_w'(gi)) && wb_lo) begin
          lower_byte_regs[gi] <= wb_data[byte_w-1:0];
        end
      end
    end
  endgenerate

  function automatic logic [word_w-1:0] pick(
    input logic [idx_w-1:0] idx,
    input logic as_byte,
    input logic hi
  );
    logic [word_w-1:0] v;
    v = 16'h0000;
    if (!as_byte)
      v = word_general_regs[idx];
    else if (hi)
      v = {8'h00, upper_byte_regs[idx]};
    else
      v = {8'h00, lower_byte_regs[idx]};
    return v;
  endfunction

  always_comb begin
    rd_a_next = pick(rd_a_idx, rd_a_byte, rd_a_hi);
    rd_b_next = pick(rd_b_idx, rd_b_byte, rd_b_hi);
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rd_a_data <= 16'h0000;
      rd_b_data <= 16'h0000;
      addr_out <= 16'h0000;
      stack_top_pointer <= 16'h0000;
    end else begin
      rd_a_data <= rd_a_next;
      rd_b_data <= rd_b_next;
      addr_out <= word_general_regs[addr_idx];
      stack_top_pointer <= word_general_regs[stack_reg_idx];
    end
  end

  // ==========================================================
  // reset sequencing
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      st_reset: state_next = st_vector;
      st_vector: if (vector_valid) state_next = st_run;
      st_run: if (exception_start) state_next = st_except;
      st_except: state_next = st_run;
      default: state_next = st_reset;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b)
      state_reg <= st_reset;
    else
      state_reg <= state_next;
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      vector_req <= 1'b0;
      vector_addr <= reset_vector_addr;
      core_ready <= 1'b0;
    end else begin
      vector_req <= (state_next == st_vector);
      vector_addr <= reset_vector_addr;
      core_ready <= (state_next == st_run) || (state_next == st_except);
    end
  end

  // ==========================================================
  // instruction pointer
  always_comb begin
    ip_next = ip_reg;
    if ((state_reg == st_vector) && vector_valid)
      ip_next = vector_data;
    else if (state_reg != st_vector && ip_load)
      ip_next = ip_data;
    else if (state_reg != st_vector && ip_step)
      ip_next = ip_reg + 16'h0002;
    ip_next[0] = 1'b0; // word fetch ignores the low bit
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ip_reg <= 16'h0000;
      next_instruction_pointer <= 16'h0000;
    end else begin
      ip_reg <= ip_next;
      next_instruction_pointer <= ip_next;
    end
  end

  // ==========================================================
  // arithmetic and flags
  assign fb.op = alu_op;
  assign fb.is_word = alu_word;
  assign fb.a = alu_a;
  assign fb.b = alu_b;
  assign fb.carry_in = flags_reg[flag_carry_bit];
  assign fb.half_in = flags_reg[flag_half_bit];
  assign fb.shift_out = alu_shift_out;
  assign fb.bit_value = alu_bit_value;

  flag_unit u_flag_unit (
    .fb(fb.unit)
  );

  // single cycle result keeps register add/sub within one state
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b)
      alu_result <= 16'h0000;
    else
      alu_result <= fb.result;
  end

  // software ops take priority over arithmetic in the same cycle;
  // the mask set at exception entry overrides both
  always_comb begin
    flags_next = (flags_reg & ~fb.flag_mask) |
      (fb.flags & fb.flag_mask);
    case (flag_op)
      flag_op_load: flags_next = flag_imm;
      flag_op_and: flags_next = flags_reg & flag_imm;
      flag_op_or: flags_next = flags_reg | flag_imm;
      flag_op_xor: flags_next = flags_reg ^ flag_imm;
      flag_op_pop: flags_next = flag_pop_word[word_w-1:byte_w];
      default: begin
      end
    endcase
    if (exception_start || (state_reg == st_reset))
      flags_next[flag_mask_bit] = 1'b1;
  end

  // other flag bits come out of reset as a plain zero here
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      flags_reg <= flag_reset_val;
      condition_flags <= flag_reset_val;
      flag_push_word <= {flag_reset_val, flag_reset_val};
      irq_masked <= 1'b1;
    end else begin
      flags_reg <= flags_next;
      condition_flags <= flags_next;
      flag_push_word <= {flags_next, flags_next};
      irq_masked <= flags_next[flag_mask_bit];
    end
  end

  branch_eval u_branch_eval (
    .flags(flags_next),
    .cond(branch_cond),
    .taken(taken_comb)
  );

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b)
      branch_taken <= 1'b0;
    else
      branch_taken <= taken_comb;
  end
endmodule

// File: regfile_pkg.sv
/*
  Package for the processor register set: widths, field positions of the
  condition flags, operation codes for the flag unit and reset values.
  Assumes one system clock and an active low asynchronous reset.
*/
// Overview of operation
// - sixteen byte registers pair into eight words
// - data access as word or either byte
// - address reads always use full word
// - eighth word register doubles as stack pointer
// - 16-bit instruction pointer, low bit forced zero
// - 8-bit flags fully software load/store/and/or/xor
// - negative, zero, overflow, carry feed branch tests
// - bit 7 masks interrupts, set on exception
// - bits 6 and 4 are free user bits
// - byte arithmetic half carry from bit 3
// - word arithmetic half carry from bit 11
// - half carry feeds decimal adjust add/sub
// - negative flag copies result sign bit
// - zero flag set on zero result
// - overflow flag set on arithmetic overflow
// - carry holds carry, borrow or shifted-out bit
// - carry acts as bit accumulator
// - each flag updates only when selected
// - 64 kbyte space through 16-bit addresses
// - register add/sub finishes in one cycle
// - reset loads vector word, sets mask bit
// - flag push doubles byte, restore drops low
package regfile_pkg;
  localparam int byte_w = 8;
  localparam int word_w = 16;
  localparam int reg_count = 8;
  localparam int idx_w = 3;
  localparam logic [idx_w-1:0] stack_reg_idx = 3'h7;
  localparam logic [word_w-1:0] reset_vector_addr = 16'h0000;
  localparam int flag_mask_bit = 7;
  localparam int flag_user_hi_bit = 6;
  localparam int flag_half_bit = 5;
  localparam int flag_user_lo_bit = 4;
  localparam int flag_neg_bit = 3;
  localparam int flag_zero_bit = 2;
  localparam int flag_ovf_bit = 1;
  localparam int flag_carry_bit = 0;
  localparam int byte_half_pos = 4;
  localparam int word_half_pos = 12;
  localparam logic [byte_w-1:0] flag_reset_val = 8'h80;
  localparam logic [byte_w-1:0] arith_flags_mask = 8'h2f;
  localparam logic [byte_w-1:0] nzv_mask = 8'h0e;
  localparam logic [byte_w-1:0] nz_mask = 8'h0c;
  localparam logic [byte_w-1:0] carry_mask = 8'h01;

  typedef enum logic [3:0] {
    alu_add = 4'h0, alu_addx = 4'h1, alu_sub = 4'h2, alu_subx = 4'h3,
    alu_cmp = 4'h4, alu_neg = 4'h5, alu_logic = 4'h6, alu_shift = 4'h7,
    alu_daa = 4'h8, alu_das = 4'h9, alu_bit = 4'ha, alu_none = 4'hf
  } alu_op_t;

  typedef enum logic [2:0] {
    flag_op_none = 3'h0, flag_op_load = 3'h1, flag_op_and = 3'h2,
    flag_op_or = 3'h3, flag_op_xor = 3'h4, flag_op_pop = 3'h5
  } flag_op_t;

  typedef enum logic [3:0] {
    br_always = 4'h0, br_never = 4'h1, br_hi = 4'h2, br_ls = 4'h3,
    br_cc = 4'h4, br_cs = 4'h5, br_ne = 4'h6, br_eq = 4'h7,
    br_vc = 4'h8, br_vs = 4'h9, br_pl = 4'ha, br_mi = 4'hb,
    br_ge = 4'hc, br_lt = 4'hd, br_gt = 4'he, br_le = 4'hf
  } branch_cond_t;

  typedef enum logic [3:0] {
    st_reset = 4'b0001, st_vector = 4'b0010, st_run = 4'b0100,
    st_except = 4'b1000
  } core_state_t;
endpackage

// File: flag_bus_if.sv
/*
  Interface carrying an arithmetic request and its flag results between
  the register set top and the flag unit. Pure combinational carrier.
*/
`timescale 1ns/10ps
interface flag_bus_if;
  import regfile_pkg::*;
  alu_op_t op;
  logic is_word;
  logic [word_w-1:0] a;
  logic [word_w-1:0] b;
  logic carry_in;
  logic half_in;
  logic shift_out;
  logic bit_value;
  logic [word_w-1:0] result;
  logic [byte_w-1:0] flags;
  logic [byte_w-1:0] flag_mask;
  modport top (output op, is_word, a, b, carry_in, half_in, shift_out,
    bit_value, input result, flags, flag_mask);
  modport unit (input op, is_word, a, b, carry_in, half_in, shift_out,
    bit_value, output result, flags, flag_mask);
endinterface

// File: flag_unit.sv
/*
  Combinational arithmetic and flag evaluation for byte and word data.
  Assumes operands are stable for a cycle and the top registers results.
*/
`timescale 1ns/10ps
module flag_unit
  import regfile_pkg::*;
(
  flag_bus_if.unit fb
);
  logic [word_w:0] sum;
  logic [word_w:0] half_sum;
  logic [word_w-1:0] am;
  logic [word_w-1:0] bm;
  logic [word_w-1:0] res;
  logic c_in;
  logic sub;
  logic msb_a;
  logic msb_b;
  logic msb_r;
  logic carry;
  logic half;
  logic [byte_w-1:0] adj;
  logic [word_w-1:0] width_mask;
  int hp;

  always_comb begin
    width_mask = fb.is_word ? 16'hffff : 16'h00ff;
    hp = fb.is_word ? word_half_pos : byte_half_pos;
    sub = (fb.op == alu_sub) || (fb.op == alu_subx) ||
      (fb.op == alu_cmp) || (fb.op == alu_neg);
    c_in = ((fb.op == alu_addx) || (fb.op == alu_subx)) ? fb.carry_in
      : 1'b0;
    am = (fb.op == alu_neg) ? 16'h0000 : (fb.a & width_mask);
    bm = (fb.op == alu_neg) ? (fb.a & width_mask) : (fb.b & width_mask);
    // subtraction as a + ~b + 1 - borrow, carry out inverted to borrow
    if (sub) begin
      sum = {1'b0, am} + {1'b0, ~bm & width_mask} + {16'h0000, ~c_in};
      half_sum = {1'b0, am & ((16'h0001 << hp) - 16'h0001)} +
        {1'b0, ~bm & ((16'h0001 << hp) - 16'h0001)} + {16'h0000, ~c_in};
    end else begin
      sum = {1'b0, am} + {1'b0, bm} + {16'h0000, c_in};
      half_sum = {1'b0, am & ((16'h0001 << hp) - 16'h0001)} +
        {1'b0, bm & ((16'h0001 << hp) - 16'h0001)} + {16'h0000, c_in};
    end
    half = half_sum[hp] ^ sub;
    carry = (fb.is_word ? sum[word_w] : sum[byte_w]) ^ sub;
    res = sum[word_w-1:0] & width_mask;
    adj = 8'h00;
    fb.flag_mask = arith_flags_mask;
    case (fb.op)
      alu_logic: begin
        res = fb.a & width_mask;
        fb.flag_mask = nzv_mask;
        carry = 1'b0;
        half = 1'b0;
      end
      alu_shift: begin
        res = fb.a & width_mask;
        carry = fb.shift_out;
        half = 1'b0;
        fb.flag_mask = nzv_mask | carry_mask;
      end
      alu_daa, alu_das: begin
        // half carry selects the low digit correction
        if (fb.half_in || ((fb.op == alu_daa) && (fb.a[3:0] > 4'h9)))
          adj[3:0] = 4'h6;
        if (fb.carry_in || ((fb.op == alu_daa) && (fb.a[7:0] > 8'h99)))
          adj[7:4] = 4'h6;
        res = (fb.op == alu_daa) ? {8'h00, fb.a[7:0] + adj}
          : {8'h00, fb.a[7:0] - adj};
        carry = fb.carry_in | ((fb.op == alu_daa) && (fb.a[7:0] > 8'h99));
        half = fb.half_in;
        fb.flag_mask = nz_mask | carry_mask;
      end
      alu_bit: begin
        res = fb.a & width_mask;
        carry = fb.bit_value;
        half = 1'b0;
        fb.flag_mask = carry_mask;
      end
      alu_none: begin
        fb.flag_mask = 8'h00;
      end
      default: begin
      end
    endcase
    msb_a = fb.is_word ? am[word_w-1] : am[byte_w-1];
    msb_b = fb.is_word ? bm[word_w-1] : bm[byte_w-1];
    msb_r = fb.is_word ? res[word_w-1] : res[byte_w-1];
    fb.result = res;
    fb.flags = 8'h00;
    fb.flags[flag_half_bit] = half;
    fb.flags[flag_neg_bit] = msb_r;
    fb.flags[flag_zero_bit] = (res == 16'h0000);
    // signed overflow; logic/shift/bit ops report none
    fb.flags[flag_ovf_bit] = ((fb.op == alu_add) || (fb.op == alu_addx))
      ? ((msb_a == msb_b) && (msb_r != msb_a))
      : sub ? ((msb_a != msb_b) && (msb_r != msb_a)) : 1'b0;
    fb.flags[flag_carry_bit] = carry;
  end
endmodule

// File: branch_eval.sv
/*
  Branch condition test on the live condition flags.
  Assumes the flag byte is the register set's next flag value before it is registered.
*/
`timescale 1ns/10ps
module branch_eval
  import regfile_pkg::*;
(
  input wire logic [byte_w-1:0] flags,
  input branch_cond_t cond,
  output logic taken
);
  logic n;
  logic z;
  logic v;
  logic c;

  always_comb begin
    n = flags[flag_neg_bit];
    z = flags[flag_zero_bit];
    v = flags[flag_ovf_bit];
    c = flags[flag_carry_bit];
    case (cond)
      br_always: taken = 1'b1;
      br_never: taken = 1'b0;
      br_hi: taken = ~(c | z);
      br_ls: taken = c | z;
      br_cc: taken = ~c;
      br_cs: taken = c;
      br_ne: taken = ~z;
      br_eq: taken = z;
      br_vc: taken = ~v;
      br_vs: taken = v;
      br_pl: taken = ~n;
      br_mi: taken = n;
      br_ge: taken = ~(n ^ v);
      br_lt: taken = n ^ v;
      br_gt: taken = ~(z | (n ^ v));
      br_le: taken = z | (n ^ v);
      default: taken = 1'b0;
    endcase
  end
endmodule

// File: vector_source.sv
/*
  Model of the execution side's reset vector fetch: answers the request
  after a few cycles. Assumes one clock shared with the register set.
*/
`timescale 1ns/10ps
module vector_source
  import regfile_pkg::*;
#(
  parameter logic [word_w-1:0] zero_word = 16'h4c33,
  parameter int wait_cycles = 3
)
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic vector_req,
  input wire logic [word_w-1:0] vector_addr,
  output logic vector_valid,
  output logic [word_w-1:0] vector_data
);
  // ==========
  // slow answer
  // data toggles outside the valid pulse so a stale word matches only every other cycle
  int count;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      count <= 0;
      vector_valid <= 1'b0;
      vector_data <= ~zero_word;
    end else begin
      vector_valid <= 1'b0;
      vector_data <= ~vector_data;
      if (vector_req && !vector_valid && count < wait_cycles) begin
        count <= count + 1;
      end else if (vector_req && !vector_valid) begin
        count <= 0;
        vector_valid <= 1'b1;
        vector_data <= (vector_addr == 16'h0000) ? zero_word : ~zero_word;
      end
    end
  end
endmodule

// File: regfile_checker.sv
/*
  Checker for the register set: pointer, vector load and flag relations.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/10ps
module regfile_checker
  import regfile_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ip_load,
  input wire logic ip_step,
  input wire logic [word_w-1:0] ip_data,
  input wire logic [word_w-1:0] next_instruction_pointer,
  input wire logic vector_req,
  input wire logic [word_w-1:0] vector_addr,
  input wire logic vector_valid,
  input wire logic [word_w-1:0] vector_data,
  input alu_op_t alu_op,
  input wire logic alu_word,
  input wire logic [word_w-1:0] alu_a,
  input wire logic [word_w-1:0] alu_b,
  input flag_op_t flag_op,
  input wire logic [byte_w-1:0] flag_imm,
  input wire logic exception_start,
  input wire logic [byte_w-1:0] condition_flags,
  input wire logic [word_w-1:0] flag_push_word,
  input wire logic irq_masked,
  input wire logic core_ready
);
  // ==========
  // reference sums
  wire logic [12:0] sum12 = {1'b0, alu_a[11:0]} + {1'b0, alu_b[11:0]};
  wire logic [4:0] sum4 = {1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]};
  wire logic [8:0] sum8 = {1'b0, alu_a[7:0]} + {1'b0, alu_b[7:0]};
  logic [8:0] sum_reg;
  logic half_reg;
  always_ff @(posedge clk_sys) begin
    sum_reg <= sum8;
  end
  always_ff @(posedge clk_sys) begin
    half_reg <= alu_word ? sum12[12] : sum4[4];
  end
  // ==========
  // properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  sequence plain_cycle;
    flag_op == flag_op_none && !exception_start;
  endsequence
  sequence byte_add;
    alu_op == alu_add && !alu_word ##0 plain_cycle;
  endsequence
  sequence vec_taken;
    vector_req && vector_valid;
  endsequence
  a_mask_mirror: assert property (irq_masked == condition_flags[7])
    else $error("mask output differs from flag bit 7");
  a_push_double: assert property (
    flag_push_word == {condition_flags, condition_flags})
    else $error("pushed flag word is not two copies");
  a_ip_even: assert property (next_instruction_pointer[0] == 1'b0)
    else $error("pointer low bit set");
  a_vector_addr: assert property (
    vector_req |-> vector_addr == reset_vector_addr)
    else $error("vector fetch address wrong");
  a_vector_load: assert property (vec_taken |=> core_ready &&
    next_instruction_pointer == ($past(vector_data) & 16'hfffe))
    else $error("pointer not loaded from vector");
  a_ip_step: assert property (core_ready && ip_step && !ip_load |=>
    next_instruction_pointer == $past(next_instruction_pointer) + 16'h0002)
    else $error("pointer step not by two");
  a_ip_load: assert property (core_ready && ip_load |=>
    next_instruction_pointer == ($past(ip_data) & 16'hfffe))
    else $error("pointer load wrong");
  a_exc_mask: assert property (
    exception_start |=> condition_flags[7])
    else $error("exception did not set mask");
  a_flag_load: assert property (
    flag_op == flag_op_load && !exception_start |=>
    condition_flags == $past(flag_imm))
    else $error("flag load wrong");
  a_flags_idle: assert property (
    alu_op == alu_none ##0 plain_cycle |=> $stable(condition_flags))
    else $error("flags changed without an update");
  a_add_nzc: assert property (byte_add |=>
    condition_flags[0] == sum_reg[8] && condition_flags[3] == sum_reg[7]
    && condition_flags[2] == (sum_reg[7:0] == 8'h00))
    else $error("byte add flags wrong");
  a_half_carry: assert property (
    alu_op == alu_add ##0 plain_cycle |=> condition_flags[5] == half_reg)
    else $error("half carry wrong");
endmodule
bind cpu_register_file_and_flags regfile_checker u_regfile_checker (.*);

// File: tb.sv
/*
  Testbench for the register set: halves, pointer, flags and branches.
  Assumes the vector source model answers the reset vector fetch.
*/
`timescale 1ns/10ps
module tb;
  import regfile_pkg::*;
  logic clk_sys, rst_b, wr_en, wr_hi, wr_lo, rd_a_byte, rd_a_hi, rd_b_byte;
  logic rd_b_hi, ip_load, ip_step, vector_req, vector_valid, alu_word;
  logic alu_dst_en, alu_shift_out, alu_bit_value, exception_start;
  logic irq_masked, branch_taken, core_ready;
  logic [2:0] wr_idx, rd_a_idx, rd_b_idx, addr_idx;
  logic [15:0] wr_data, rd_a_data, rd_b_data, addr_out, stack_top_pointer;
  logic [15:0] ip_data, next_instruction_pointer, vector_addr, vector_data;
  logic [15:0] alu_a, alu_b, alu_result, flag_pop_word, flag_push_word;
  logic [7:0] flag_imm, condition_flags;
  alu_op_t alu_op;
  flag_op_t flag_op;
  branch_cond_t branch_cond;
  int miscompares, num_checks;
  cpu_register_file_and_flags u_cpu_register_file_and_flags (.*);
  vector_source u_vector_source (.clk_sys(clk_sys), .rst_b(rst_b),
    .vector_req(vector_req), .vector_addr(vector_addr),
    .vector_valid(vector_valid), .vector_data(vector_data));
  // ==========
  // access tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cf(input logic [7:0] e);
    chk({8'h00, condition_flags}, {8'h00, e});
  endtask
  task automatic wr(input logic [2:0] i, input logic h, input logic l,
      input logic [15:0] d);
    @(posedge clk_sys);
    wr_en <= 1'b1;
    wr_idx <= i;
    wr_hi <= h;
    wr_lo <= l;
    wr_data <= d;
    @(posedge clk_sys);
    wr_en <= 1'b0;
    #1;
  endtask
  // port b always reads the upper byte of the same register
  task automatic rd(input logic [2:0] i, input logic b, input logic h);
    @(posedge clk_sys);
    rd_a_idx <= i;
    rd_a_byte <= b;
    rd_a_hi <= h;
    rd_b_idx <= i;
    rd_b_byte <= 1'b1;
    rd_b_hi <= 1'b1;
    addr_idx <= i;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic ipdo(input logic l, input logic s, input logic [15:0] d);
    @(posedge clk_sys);
    ip_load <= l;
    ip_step <= s;
    ip_data <= d;
    @(posedge clk_sys);
    ip_load <= 1'b0;
    ip_step <= 1'b0;
    #1;
  endtask
  task automatic fl(input flag_op_t op, input logic [7:0] imm,
      input logic [15:0] pop, input logic exc);
    @(posedge clk_sys);
    flag_op <= op;
    flag_imm <= imm;
    flag_pop_word <= pop;
    exception_start <= exc;
    @(posedge clk_sys);
    flag_op <= flag_op_none;
    exception_start <= 1'b0;
    #1;
  endtask
  task automatic alu(input alu_op_t op, input logic w, input logic [15:0] a,
      input logic [15:0] b, input logic [1:0] sb, input logic dst);
    @(posedge clk_sys);
    alu_op <= op;
    alu_word <= w;
    alu_a <= a;
    alu_b <= b;
    {alu_shift_out, alu_bit_value} <= sb;
    alu_dst_en <= dst;
    wr_idx <= 3'h5;
    @(posedge clk_sys);
    alu_op <= alu_none;
    alu_dst_en <= 1'b0;
    #1;
  endtask
  task automatic br(input logic [15:0] m);
    for (int i = 0; i < 16; i++) begin
      @(posedge clk_sys);
      branch_cond <= branch_cond_t'(i[3:0]);
      @(posedge clk_sys);
      #1;
      chk({15'h0000, branch_taken}, {15'h0000, m[i]});
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ==========
  // clock and sequence
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  initial begin
    int n;
    {rst_b, wr_en, wr_hi, wr_lo, rd_a_byte, rd_a_hi, rd_b_byte, rd_b_hi,
      ip_load, ip_step, alu_word, alu_dst_en, alu_shift_out, alu_bit_value,
      exception_start} = '0;
    {wr_idx, rd_a_idx, rd_b_idx, addr_idx, wr_data, ip_data, alu_a, alu_b,
      flag_pop_word, flag_imm} = '0;
    alu_op = alu_none;
    flag_op = flag_op_none;
    branch_cond = br_always;
    repeat (8) @(posedge clk_sys);
    #1;
    cf(8'h80);
    chk(flag_push_word, 16'h8080);
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    for (n = 0; n < 50 && core_ready !== 1'b1; n++) begin
      @(posedge clk_sys);
    end
    #1;
    if (core_ready !== 1'b1) begin
      $display("wrong value at %0t: vector never taken", $time);
      miscompares++;
      results();
    end
    chk(next_instruction_pointer, 16'h4c32);
    for (n = 0; n < 8; n++) begin
      wr(n[2:0], 1'b1, 1'b1, {4{n[3:0]}} ^ 16'h5a00);
    end
    for (n = 0; n < 8; n++) begin
      rd(n[2:0], 1'b0, 1'b0);
      chk(rd_a_data, {4{n[3:0]}} ^ 16'h5a00);
    end
    wr(3'h3, 1'b1, 1'b1, 16'h1234);
    rd(3'h3, 1'b1, 1'b0);
    chk(rd_a_data, 16'h0034);
    chk(rd_b_data, 16'h0012);
    chk(addr_out, 16'h1234);
    wr(3'h3, 1'b1, 1'b0, 16'h00ab);
    wr(3'h3, 1'b0, 1'b1, 16'h00cd);
    rd(3'h3, 1'b0, 1'b0);
    chk(rd_a_data, 16'habcd);
    wr(3'h7, 1'b1, 1'b1, 16'h0ffe);
    rd(3'h7, 1'b0, 1'b0);
    chk(stack_top_pointer, 16'h0ffe);
    ipdo(1'b0, 1'b1, 16'h0000);
    chk(next_instruction_pointer, 16'h4c34);
    ipdo(1'b1, 1'b0, 16'hffff);
    chk(next_instruction_pointer, 16'hfffe);
    ipdo(1'b0, 1'b1, 16'h0000);
    chk(next_instruction_pointer, 16'h0000);
    fl(flag_op_load, 8'hff, 16'h0000, 1'b0);
    chk(flag_push_word, 16'hffff);
    fl(flag_op_and, 8'h5a, 16'h0000, 1'b0);
    cf(8'h5a);
    fl(flag_op_or, 8'h21, 16'h0000, 1'b0);
    cf(8'h7b);
    fl(flag_op_xor, 8'hff, 16'h0000, 1'b0);
    cf(8'h84);
    fl(flag_op_pop, 8'h00, 16'h3ca5, 1'b0);
    cf(8'h3c);
    fl(flag_op_none, 8'h00, 16'h0000, 1'b1);
    cf(8'hbc);
    fl(flag_op_load, 8'h50, 16'h0000, 1'b0);
    alu(alu_add, 1'b0, 16'h000f, 16'h0001, 2'b00, 1'b0);
    chk({8'h00, alu_result[7:0]}, 16'h0010);
    cf(8'h70);
    alu(alu_add, 1'b0, 16'h007f, 16'h0001, 2'b00, 1'b0);
    cf(8'h7a);
    alu(alu_add, 1'b0, 16'h00ff, 16'h0001, 2'b00, 1'b0);
    cf(8'h75);
    alu(alu_add, 1'b1, 16'h0fff, 16'h0001, 2'b00, 1'b0);
    chk(alu_result, 16'h1000);
    cf(8'h70);
    alu(alu_add, 1'b1, 16'h00ff, 16'h0001, 2'b00, 1'b0);
    cf(8'h50);
    alu(alu_sub, 1'b0, 16'h0000, 16'h0001, 2'b00, 1'b0);
    cf(8'h79);
    alu(alu_none, 1'b0, 16'h00ff, 16'h00ff, 2'b11, 1'b0);
    cf(8'h79);
    alu(alu_bit, 1'b0, 16'h0000, 16'h0000, 2'b00, 1'b0);
    cf(8'h78);
    alu(alu_shift, 1'b0, 16'h0000, 16'h0000, 2'b10, 1'b0);
    cf(8'h75);
    br(16'h95a9);
    fl(flag_op_load, 8'h0a, 16'h0000, 1'b0);
    br(16'h5a55);
    fl(flag_op_load, 8'h21, 16'h0000, 1'b0);
    alu(alu_daa, 1'b0, 16'h0012, 16'h0000, 2'b00, 1'b0);
    chk(alu_result, 16'h0078);
    cf(8'h21);
    alu(alu_neg, 1'b0, 16'h0001, 16'h0000, 2'b00, 1'b0);
    cf(8'h29);
    alu(alu_logic, 1'b0, 16'h0000, 16'h0000, 2'b00, 1'b0);
    cf(8'h25);
    wr(3'h5, 1'b1, 1'b1, 16'h1234);
    alu(alu_add, 1'b0, 16'h0001, 16'h0002, 2'b00, 1'b1);
    rd(3'h5, 1'b0, 1'b0);
    chk(rd_a_data, 16'h1203);
    results();
  end
endmodule
